// ---- pkg/pfcvp_defs.vh ----
// constants for the pfc voltage and frequency protection block
`ifndef PFCVP_DEFS_VH
`define PFCVP_DEFS_VH

// ****************************************
// register offsets
// ****************************************
`define PFCVP_ADDR_CTRL        8'h00
`define PFCVP_ADDR_FAULT       8'h04
`define PFCVP_ADDR_STATUS      8'h08
`define PFCVP_ADDR_AC_RMS      8'h0c
`define PFCVP_ADDR_PERIOD      8'h10
`define PFCVP_ADDR_BUS_V       8'h14
`define PFCVP_ADDR_OFFSET      8'h18
`define PFCVP_ADDR_AC_OV_THR   8'h20
`define PFCVP_ADDR_AC_OV_HYS   8'h24
`define PFCVP_ADDR_AC_BO_THR   8'h28
`define PFCVP_ADDR_AC_BO_HYS   8'h2c
`define PFCVP_ADDR_AC_OV_WIN   8'h30
`define PFCVP_ADDR_AC_BO_WIN   8'h34
`define PFCVP_ADDR_AC_REC_WIN  8'h38
`define PFCVP_ADDR_PER_UP      8'h40
`define PFCVP_ADDR_PER_UP_HYS  8'h44
`define PFCVP_ADDR_PER_LO      8'h48
`define PFCVP_ADDR_PER_LO_HYS  8'h4c
`define PFCVP_ADDR_PER_WIN     8'h50
`define PFCVP_ADDR_BUS_OV_THR  8'h60
`define PFCVP_ADDR_BUS_OV_HYS  8'h64
`define PFCVP_ADDR_BUS_OL_THR  8'h68
`define PFCVP_ADDR_BUS_OL_HYS  8'h6c
`define PFCVP_ADDR_BUS_OV_WIN  8'h70
`define PFCVP_ADDR_BUS_OL_WIN  8'h74
`define PFCVP_ADDR_BUS_REC_WIN 8'h78
`define PFCVP_ADDR_OFS_LO      8'h80
`define PFCVP_ADDR_OFS_UP      8'h84

// ****************************************
// field positions
// ****************************************
`define PFCVP_CTRL_RUN         0
`define PFCVP_CTRL_SEL60       1
`define PFCVP_FLT_OPENLOOP     1
`define PFCVP_FLT_BUS_OV       2
`define PFCVP_FLT_FREQ         3
`define PFCVP_FLT_BROWNOUT     4
`define PFCVP_FLT_AC_OV        5
`define PFCVP_FLT_OFFSET       7

// ****************************************
// start-up states
// ****************************************
`define PFCVP_ST_IDLE          2'h0
`define PFCVP_ST_CHECK         2'h1
`define PFCVP_ST_RUN           2'h2
`define PFCVP_ST_FAULT         2'h3

// ****************************************
// reset values
// ****************************************
`define PFCVP_RST_AC_OV_THR    16'hffff
`define PFCVP_RST_AC_BO_THR    16'h0000
`define PFCVP_RST_HYS          16'h0000
`define PFCVP_RST_WIN          16'h0002
`define PFCVP_RST_PER_UP_50    16'h0000
`define PFCVP_RST_PER_UP       16'hffff
`define PFCVP_RST_PER_LO       16'h0000
`define PFCVP_RST_BUS_OV_THR   16'hffff
`define PFCVP_RST_BUS_OL_THR   16'h0000
`define PFCVP_RST_OFS_LO       16'h0000
`define PFCVP_RST_OFS_UP       16'hffff

`endif

// ---- rtl/pfcvp_protection.v ----
// pfc input, line frequency and bus voltage protection with offset check
//
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "pfcvp_defs.vh"

module pfcvp_protection #(
    parameter DW = 16,
    parameter WW = 16
) (
    input  wire          CORE_CLK_I,
    input  wire          RESET_N_I,
    input  wire          CLK_EN_I,
    input  wire [7:0]    REG_ADDR_I,
    input  wire [31:0]   REG_WDATA_I,
    input  wire          REG_WR_I,
    input  wire          REG_RD_I,
    output reg  [31:0]   REG_RDATA_O,
    input  wire          BASE_TICK_I,
    input  wire [DW-1:0] AC_SAMPLE_I,
    input  wire          ZERO_CROSS_I,
    input  wire [DW-1:0] AC_RMS_I,
    input  wire          SWITCH_TICK_I,
    input  wire [DW-1:0] BUS_SAMPLE_I,
    input  wire          SUPERVISE_TICK_I,
    input  wire          OFFSET_VALID_I,
    input  wire [DW-1:0] OFFSET_SAMPLE_I,
    output reg  [7:0]    FAULT_WORD_O,
    output wire          DUTY_ZERO_O,
    output wire          RUN_STATUS_O,
    output wire          START_BLOCK_O
);

    // ****************************************
    // reset synchroniser
    // ****************************************
    reg rst_meta_n;
    reg rst_n;
    always @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    // ****************************************
    // configuration registers
    // ****************************************
    // control bits
    reg          run_cmd;
    reg          sel_60;

    // ac input limits
    reg [DW-1:0] ac_overvoltage_threshold;
    reg [DW-1:0] ac_overvoltage_hysteresis;
    reg [DW-1:0] ac_brownout_threshold;
    reg [DW-1:0] ac_brownout_hysteresis;
    reg [WW-1:0] ac_overvoltage_set_window;
    reg [WW-1:0] ac_brownout_set_window;
    reg [WW-1:0] ac_recovery_window;

    // line period limits
    reg [DW-1:0] period_upper_limit;
    reg [DW-1:0] period_upper_hysteresis;
    reg [DW-1:0] period_lower_limit;
    reg [DW-1:0] period_lower_hysteresis;
    reg [WW-1:0] period_check_window;

    // bus voltage limits
    reg [DW-1:0] bus_overvoltage_threshold;
    reg [DW-1:0] bus_overvoltage_hysteresis;
    reg [DW-1:0] bus_openloop_threshold;
    reg [DW-1:0] bus_openloop_hysteresis;
    reg [WW-1:0] bus_overvoltage_set_window;
    reg [WW-1:0] bus_openloop_set_window;
    reg [WW-1:0] bus_recovery_window;

    // offset limits
    reg [DW-1:0] current_offset_lower_limit;
    reg [DW-1:0] current_offset_upper_limit;

    // write data slices
    wire [DW-1:0] wd = REG_WDATA_I[DW-1:0];
    wire [WW-1:0] ww = REG_WDATA_I[WW-1:0];

    always @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            run_cmd                    <= 1'b0;
            sel_60                     <= 1'b0;
            ac_overvoltage_threshold   <= `PFCVP_RST_AC_OV_THR;
            ac_overvoltage_hysteresis  <= `PFCVP_RST_HYS;
            ac_brownout_threshold      <= `PFCVP_RST_AC_BO_THR;
            ac_brownout_hysteresis     <= `PFCVP_RST_HYS;
            ac_overvoltage_set_window  <= `PFCVP_RST_WIN;
            ac_brownout_set_window     <= `PFCVP_RST_WIN;
            ac_recovery_window         <= `PFCVP_RST_WIN;
            period_upper_limit         <= `PFCVP_RST_PER_UP;
            period_upper_hysteresis    <= `PFCVP_RST_HYS;
            period_lower_limit         <= `PFCVP_RST_PER_LO;
            period_lower_hysteresis    <= `PFCVP_RST_HYS;
            period_check_window        <= `PFCVP_RST_WIN;
            bus_overvoltage_threshold  <= `PFCVP_RST_BUS_OV_THR;
            bus_overvoltage_hysteresis <= `PFCVP_RST_HYS;
            bus_openloop_threshold     <= `PFCVP_RST_BUS_OL_THR;
            bus_openloop_hysteresis    <= `PFCVP_RST_HYS;
            bus_overvoltage_set_window <= `PFCVP_RST_WIN;
            bus_openloop_set_window    <= `PFCVP_RST_WIN;
            bus_recovery_window        <= `PFCVP_RST_WIN;
            current_offset_lower_limit <= `PFCVP_RST_OFS_LO;
            current_offset_upper_limit <= `PFCVP_RST_OFS_UP;
        end else if (CLK_EN_I && REG_WR_I) begin
            case (REG_ADDR_I)
                `PFCVP_ADDR_CTRL: begin
                    run_cmd <= REG_WDATA_I[`PFCVP_CTRL_RUN];
                    sel_60  <= REG_WDATA_I[`PFCVP_CTRL_SEL60];
                end

                // ac limits and windows
                `PFCVP_ADDR_AC_OV_THR:   ac_overvoltage_threshold   <= wd;
                `PFCVP_ADDR_AC_OV_HYS:   ac_overvoltage_hysteresis  <= wd;
                `PFCVP_ADDR_AC_BO_THR:   ac_brownout_threshold      <= wd;
                `PFCVP_ADDR_AC_BO_HYS:   ac_brownout_hysteresis     <= wd;
                `PFCVP_ADDR_AC_OV_WIN:   ac_overvoltage_set_window  <= ww;
                `PFCVP_ADDR_AC_BO_WIN:   ac_brownout_set_window     <= ww;
                `PFCVP_ADDR_AC_REC_WIN:  ac_recovery_window         <= ww;

                // period limits and window
                `PFCVP_ADDR_PER_UP:      period_upper_limit         <= wd;
                `PFCVP_ADDR_PER_UP_HYS:  period_upper_hysteresis    <= wd;
                `PFCVP_ADDR_PER_LO:      period_lower_limit         <= wd;
                `PFCVP_ADDR_PER_LO_HYS:  period_lower_hysteresis    <= wd;
                `PFCVP_ADDR_PER_WIN:     period_check_window        <= ww;

                // bus limits and windows
                `PFCVP_ADDR_BUS_OV_THR:  bus_overvoltage_threshold  <= wd;
                `PFCVP_ADDR_BUS_OV_HYS:  bus_overvoltage_hysteresis <= wd;
                `PFCVP_ADDR_BUS_OL_THR:  bus_openloop_threshold     <= wd;
                `PFCVP_ADDR_BUS_OL_HYS:  bus_openloop_hysteresis    <= wd;
                `PFCVP_ADDR_BUS_OV_WIN:  bus_overvoltage_set_window <= ww;
                `PFCVP_ADDR_BUS_OL_WIN:  bus_openloop_set_window    <= ww;
                `PFCVP_ADDR_BUS_REC_WIN: bus_recovery_window        <= ww;

                // offset limits
                `PFCVP_ADDR_OFS_LO:      current_offset_lower_limit <= wd;
                `PFCVP_ADDR_OFS_UP:      current_offset_upper_limit <= wd;
                default: ;
            endcase
        end
    end

    // ****************************************
    // measurements
    // ****************************************
    reg [DW-1:0] ac_sample;
    reg [DW-1:0] ac_rms;
    reg [DW-1:0] period_counter;
    reg [DW-1:0] half_cycle_period_count;
    reg [DW-1:0] bus_voltage;
    reg [DW-1:0] current_sense_offset;

    // crossing qualified by base tick
    wire         zc_tick = BASE_TICK_I & ZERO_CROSS_I;

    always @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            ac_sample               <= {DW{1'b0}};
            ac_rms                  <= {DW{1'b0}};
            period_counter          <= {DW{1'b0}};
            half_cycle_period_count <= {DW{1'b0}};
            bus_voltage             <= {DW{1'b0}};
        end else if (CLK_EN_I) begin
            if (BASE_TICK_I) begin
                ac_sample <= AC_SAMPLE_I;
                if (ZERO_CROSS_I) begin
                    ac_rms                  <= AC_RMS_I;
                    half_cycle_period_count <= period_counter;
                    period_counter          <= {DW{1'b0}};
                end else if (period_counter != {DW{1'b1}}) begin
                    period_counter <= period_counter + 1'b1;
                end
            end
            if (SWITCH_TICK_I)
                bus_voltage <= BUS_SAMPLE_I;
        end
    end

    // ****************************************
    // deglitch channels
    // ****************************************
    // 0 openloop, 1 bus ov, 2 freq hi-period, 3 freq lo-period,
    // 4 brownout, 5 ac ov
    wire [5:0]    trip;
    wire [5:0]    okay;
    wire [5:0]    tick;
    wire [5:0]    active;
    wire [6*WW-1:0] set_win;
    wire [6*WW-1:0] rec_win;


    // bus open loop
    assign trip[0] = bus_voltage < bus_openloop_threshold;
    assign okay[0] = bus_voltage > bus_openloop_threshold + bus_openloop_hysteresis;

    // bus overvoltage
    assign trip[1] = bus_voltage > bus_overvoltage_threshold;
    assign okay[1] = bus_voltage < bus_overvoltage_threshold - bus_overvoltage_hysteresis;

    // long period, low frequency
    assign trip[2] = half_cycle_period_count > period_upper_limit;
    assign okay[2] = half_cycle_period_count < period_upper_limit - period_upper_hysteresis;

    // short period, high frequency
    assign trip[3] = half_cycle_period_count < period_lower_limit;
    assign okay[3] = half_cycle_period_count > period_lower_limit + period_lower_hysteresis;

    // ac brownout
    assign trip[4] = ac_rms < ac_brownout_threshold;
    assign okay[4] = ac_rms > ac_brownout_threshold + ac_brownout_hysteresis;

    // ac overvoltage
    assign trip[5] = ac_rms > ac_overvoltage_threshold;
    assign okay[5] = ac_rms < ac_overvoltage_threshold - ac_overvoltage_hysteresis;


    // channel tick selection
    assign tick[1:0] = {2{SWITCH_TICK_I}};
    assign tick[3:2] = {2{SUPERVISE_TICK_I}};
    assign tick[5:4] = {2{zc_tick}};


    // set and recovery windows
    assign set_win = {ac_overvoltage_set_window, ac_brownout_set_window,
                      period_check_window, period_check_window,
                      bus_overvoltage_set_window, bus_openloop_set_window};
    assign rec_win = {ac_recovery_window, ac_recovery_window,
                      period_check_window, period_check_window,
                      bus_recovery_window, bus_recovery_window};

    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1) begin : chan
            reg  [WW-1:0] cnt;
            reg           act;
            wire          cond    = active[g] ? okay[g] : trip[g];
            wire [WW-1:0] win     = active[g] ? rec_win[g*WW +: WW] : set_win[g*WW +: WW];
            wire [WW-1:0] cnt_inc = cnt + 1'b1;
            assign active[g] = act;
            always @(posedge CORE_CLK_I or negedge rst_n) begin
                if (!rst_n) begin
                    cnt <= {WW{1'b0}};
                    act <= 1'b0;
                end else if (CLK_EN_I && tick[g]) begin
                    if (!cond) begin
                        cnt <= {WW{1'b0}};
                    end else if (cnt_inc >= win) begin
                        cnt <= {WW{1'b0}};
                        act <= ~act;
                    end else begin
                        cnt <= cnt_inc;
                    end
                end
            end
        end
    endgenerate

    // ****************************************
    // start-up offset check
    // ****************************************
    reg [1:0] state;
    reg [1:0] next_state;

    // sample outside offset limits
    wire      offset_bad = (OFFSET_SAMPLE_I < current_offset_lower_limit) ||
                           (OFFSET_SAMPLE_I > current_offset_upper_limit);

    always @* begin
        case (state)
            `PFCVP_ST_IDLE:  next_state = run_cmd ? `PFCVP_ST_CHECK : `PFCVP_ST_IDLE;
            `PFCVP_ST_CHECK: begin
                if (!OFFSET_VALID_I)
                    next_state = `PFCVP_ST_CHECK;
                else if (offset_bad)
                    next_state = `PFCVP_ST_FAULT;
                else
                    next_state = `PFCVP_ST_RUN;
            end
            `PFCVP_ST_RUN:   next_state = run_cmd ? `PFCVP_ST_RUN : `PFCVP_ST_IDLE;
            `PFCVP_ST_FAULT: next_state = `PFCVP_ST_FAULT;
            default:         next_state = `PFCVP_ST_IDLE;
        endcase
    end

    always @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            state                <= `PFCVP_ST_IDLE;
            current_sense_offset <= {DW{1'b0}};
        end else if (CLK_EN_I) begin
            state <= next_state;
            if (state == `PFCVP_ST_CHECK && OFFSET_VALID_I)
                current_sense_offset <= OFFSET_SAMPLE_I;
        end
    end

    // ****************************************
    // fault word and gate control
    // ****************************************
    always @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n)
            FAULT_WORD_O <= 8'h00;
        else if (CLK_EN_I)
            FAULT_WORD_O <= {next_state == `PFCVP_ST_FAULT, 1'b0, active[5], active[4],
                             active[3] | active[2], active[1], active[0], 1'b0};
    end

    assign DUTY_ZERO_O   = |FAULT_WORD_O[5:1];
    assign START_BLOCK_O = FAULT_WORD_O[`PFCVP_FLT_OFFSET];
    assign RUN_STATUS_O  = (state == `PFCVP_ST_RUN) && !DUTY_ZERO_O;

    // ****************************************
    // register read port
    // ****************************************
    always @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            REG_RDATA_O <= 32'h00000000;
        end else if (CLK_EN_I) begin
            REG_RDATA_O <= 32'h00000000;
            if (REG_RD_I) begin
                case (REG_ADDR_I)
                    `PFCVP_ADDR_CTRL:    REG_RDATA_O[1:0] <= {sel_60, run_cmd};
                    `PFCVP_ADDR_FAULT:   REG_RDATA_O[7:0] <= FAULT_WORD_O;
                    `PFCVP_ADDR_STATUS:  REG_RDATA_O[3:0] <= {state, DUTY_ZERO_O, RUN_STATUS_O};

                    // measurements
                    `PFCVP_ADDR_AC_RMS:  REG_RDATA_O[DW-1:0] <= ac_rms;
                    `PFCVP_ADDR_PERIOD:  REG_RDATA_O[DW-1:0] <= half_cycle_period_count;
                    `PFCVP_ADDR_BUS_V:   REG_RDATA_O[DW-1:0] <= bus_voltage;
                    `PFCVP_ADDR_OFFSET:  REG_RDATA_O[DW-1:0] <= current_sense_offset;

                    // readable limits
                    `PFCVP_ADDR_PER_UP:  REG_RDATA_O[DW-1:0] <= period_upper_limit;
                    `PFCVP_ADDR_PER_LO:  REG_RDATA_O[DW-1:0] <= period_lower_limit;
                    `PFCVP_ADDR_AC_OV_THR: REG_RDATA_O[DW-1:0] <= ac_overvoltage_threshold;
                    `PFCVP_ADDR_AC_BO_THR: REG_RDATA_O[DW-1:0] <= ac_brownout_threshold;
                    `PFCVP_ADDR_BUS_OV_THR: REG_RDATA_O[DW-1:0] <= bus_overvoltage_threshold;
                    `PFCVP_ADDR_BUS_OL_THR: REG_RDATA_O[DW-1:0] <= bus_openloop_threshold;
                    default: REG_RDATA_O <= 32'h00000000;
                endcase
            end
        end
    end

endmodule
`default_nettype wire

// ---- dv/pfcvp_front_end.sv ----
// behavioural front end feeding ticks and sensed values
`timescale 1ns/100ps
`default_nettype none
module pfcvp_front_end (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [15:0] rms_set_i,
    input  wire logic [15:0] bus_set_i,
    input  wire logic [15:0] ac_set_i,
    input  wire logic [15:0] half_set_i,
    input  wire logic [15:0] ofs_set_i,
    input  wire logic        ofs_go_i,
    output logic             base_tick_o,
    output logic             cross_o,
    output logic             sw_tick_o,
    output logic             sup_tick_o,
    output logic             ofs_valid_o,
    output logic [15:0]      rms_o,
    output logic [15:0]      ac_o,
    output logic [15:0]      bus_o,
    output logic [15:0]      ofs_o
);
    logic [5:0]  cyc;
    logic [15:0] base_cnt;
    // ****************************************
    // ticks and sensed values
    // ****************************************
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cyc <= 6'h00;
            base_cnt <= 16'h0000;
            base_tick_o <= 1'b0;
            cross_o <= 1'b0;
            sw_tick_o <= 1'b0;
            sup_tick_o <= 1'b0;
            ofs_valid_o <= 1'b0;
            rms_o <= 16'h0000;
            ac_o <= 16'h0000;
            bus_o <= 16'h0000;
            ofs_o <= 16'h0000;
        end else begin
            cyc <= cyc + 6'h01;
            base_tick_o <= cyc[0];
            cross_o <= cyc[0] && (base_cnt + 16'h0001 >= half_set_i);
            if (cyc[0]) begin
                base_cnt <= (base_cnt + 16'h0001 >= half_set_i) ? 16'h0000 : base_cnt + 16'h0001;
            end
            sw_tick_o <= (cyc[1:0] == 2'h3);
            sup_tick_o <= (cyc == 6'h3f);
            ofs_valid_o <= ofs_go_i;
            rms_o <= rms_set_i;
            ac_o <= ac_set_i;
            bus_o <= bus_set_i;
            ofs_o <= ofs_go_i ? ofs_set_i : ~ofs_o;
        end
    end
endmodule
`default_nettype wire

// ---- dv/pfcvp_protection_props.sv ----
// port checker for the protection block
`timescale 1ns/100ps
`default_nettype none
module pfcvp_protection_props (
    input wire logic       CORE_CLK_I,
    input wire logic       RESET_N_I,
    input wire logic       BASE_TICK_I,
    input wire logic       ZERO_CROSS_I,
    input wire logic       SWITCH_TICK_I,
    input wire logic       SUPERVISE_TICK_I,
    input wire logic       OFFSET_VALID_I,
    input wire logic [7:0] FAULT_WORD_O,
    input wire logic       DUTY_ZERO_O,
    input wire logic       RUN_STATUS_O,
    input wire logic       START_BLOCK_O
);
    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (!RESET_N_I);
    // ****************************************
    // assertions and cover points
    // ****************************************
    AST_DUTY_FROM_FAULTS: assert property (DUTY_ZERO_O == (|FAULT_WORD_O[5:1]))
        else $error("duty zero does not follow fault bits");
    AST_STATUS_OFF: assert property ((DUTY_ZERO_O || START_BLOCK_O) |-> !RUN_STATUS_O)
        else $error("run status on while forced off");
    AST_AC_ON_CROSSING: assert property ($changed(FAULT_WORD_O[5:4]) |->
        $past(BASE_TICK_I && ZERO_CROSS_I) || $past(BASE_TICK_I && ZERO_CROSS_I, 2)
        || $past(BASE_TICK_I && ZERO_CROSS_I, 3)) else $error("ac fault moved off a crossing");
    AST_BUS_ON_SWITCH: assert property ($changed(FAULT_WORD_O[2:1]) |->
        $past(SWITCH_TICK_I) || $past(SWITCH_TICK_I, 2) || $past(SWITCH_TICK_I, 3))
        else $error("bus fault moved off a switching tick");
    AST_FREQ_ON_SUPERVISE: assert property ($changed(FAULT_WORD_O[3]) |->
        $past(SUPERVISE_TICK_I) || $past(SUPERVISE_TICK_I, 2) || $past(SUPERVISE_TICK_I, 3))
        else $error("frequency fault moved off a supervision tick");
    AST_OFFSET_ON_VALID: assert property ($rose(FAULT_WORD_O[7]) |->
        $past(OFFSET_VALID_I) || $past(OFFSET_VALID_I, 2)) else $error("offset fault without sample");
    AST_OFFSET_LATCHED: assert property (FAULT_WORD_O[7] |=> FAULT_WORD_O[7])
        else $error("offset fault released without reset");
    AST_BLOCK_MIRROR: assert property (START_BLOCK_O == FAULT_WORD_O[7])
        else $error("start block differs from offset fault");
    COV_AC_OV: cover property ($rose(FAULT_WORD_O[5]));
    COV_FREQ: cover property ($rose(FAULT_WORD_O[3]));
    COV_OPEN_CLEAR: cover property ($fell(FAULT_WORD_O[1]));
    COV_OFFSET: cover property ($rose(FAULT_WORD_O[7]));
endmodule
bind pfcvp_protection pfcvp_protection_props i_pfcvp_protection_props (
    .CORE_CLK_I(CORE_CLK_I), .RESET_N_I(RESET_N_I), .BASE_TICK_I(BASE_TICK_I),
    .ZERO_CROSS_I(ZERO_CROSS_I), .SWITCH_TICK_I(SWITCH_TICK_I),
    .SUPERVISE_TICK_I(SUPERVISE_TICK_I), .OFFSET_VALID_I(OFFSET_VALID_I),
    .FAULT_WORD_O(FAULT_WORD_O), .DUTY_ZERO_O(DUTY_ZERO_O), .RUN_STATUS_O(RUN_STATUS_O),
    .START_BLOCK_O(START_BLOCK_O));
`default_nettype wire

// ---- dv/pfcvp_protection_bench.sv ----
// self-checking bench for the protection block
`timescale 1ns/100ps
`default_nettype none
module pfcvp_protection_bench;
    logic        clk = 1'b0;
    logic        rst_n = 1'b1;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        ofs_go = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] seed = 32'h0000aa01;
    logic [15:0] rms_s = 16'h0320;
    logic [15:0] bus_s = 16'h07d0;
    logic [15:0] half_s = 16'h000e;
    logic [15:0] ofs_s = 16'h0100;
    logic [7:0]  mfw = 8'h00;
    logic [31:0] rdata;
    logic [15:0] rms, ac, bus, ofs;
    logic [7:0]  fw;
    logic        bt, zc, st, sup, ov, duty, runst, blk;
    integer      errors = 0;
    integer      compares = 0;
    integer      cycles = 0;
    integer      o, b, r;
    integer      thr[6] = '{1000, 500, 3000, 1000, 20, 6};
    integer      hys[6] = '{100, 50, 200, 100, 4, 2};
    integer      nom[6] = '{800, 800, 2000, 2000, 13, 13};
    integer      bp[6] = '{5, 4, 2, 1, 3, 3};
    logic [7:0]  ra[8] = '{8'h00, 8'h04, 8'h08, 8'h20, 8'h28, 8'h40, 8'h24, 8'hfc};
    logic [15:0] rv[8] = '{16'h0, 16'h0, 16'h0, 16'hffff, 16'h0, 16'hffff, 16'h0, 16'h0};
    logic [23:0] cfg[19] = '{24'h2003e8, 24'h240064, 24'h2801f4, 24'h2c0032, 24'h300006,
        24'h340006, 24'h380006, 24'h400014, 24'h440004, 24'h480006, 24'h4c0002, 24'h500006,
        24'h600bb8, 24'h6400c8, 24'h6803e8, 24'h6c0064, 24'h700006, 24'h740006, 24'h780006};
    pfcvp_protection i_pfcvp_protection (
        .CORE_CLK_I(clk), .RESET_N_I(rst_n), .CLK_EN_I(1'b1), .REG_ADDR_I(addr),
        .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata),
        .BASE_TICK_I(bt), .AC_SAMPLE_I(ac), .ZERO_CROSS_I(zc), .AC_RMS_I(rms),
        .SWITCH_TICK_I(st), .BUS_SAMPLE_I(bus), .SUPERVISE_TICK_I(sup), .OFFSET_VALID_I(ov),
        .OFFSET_SAMPLE_I(ofs), .FAULT_WORD_O(fw), .DUTY_ZERO_O(duty), .RUN_STATUS_O(runst),
        .START_BLOCK_O(blk));
    pfcvp_front_end i_pfcvp_front_end (
        .clk_i(clk), .rst_n_i(rst_n), .rms_set_i(rms_s), .bus_set_i(bus_s),
        .ac_set_i(seed[15:0]), .half_set_i(half_s), .ofs_set_i(ofs_s), .ofs_go_i(ofs_go),
        .base_tick_o(bt), .cross_o(zc), .sw_tick_o(st), .sup_tick_o(sup), .ofs_valid_o(ov),
        .rms_o(rms), .ac_o(ac), .bus_o(bus), .ofs_o(ofs));
    // ****************************************
    // clock, random source and helpers
    // ****************************************
    always #50 clk = ~clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic test_done();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        seed <= xs(seed);
        cycles <= cycles + 1;
        if (cycles > 20000) begin
            errors++;
            test_done();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #10;
        chk($sformatf("register %h", a), e, rdata);
    endtask
    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask
    task automatic pulse(input logic [15:0] v);
        @(posedge clk);
        ofs_s <= v;
        ofs_go <= 1'b1;
        @(posedge clk);
        ofs_go <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic ticks(input integer ch, input integer n);
        integer k;
        k = 0;
        while (k < n) begin
            @(negedge clk);
            if (ch < 2 ? (bt && zc) : (ch < 4 ? st : sup)) k++;
        end
    endtask
    task automatic phase(input integer ch, input integer v, input integer n);
        logic up;
        up = (ch % 2 == 0);
        @(posedge clk);
        if (ch < 2) rms_s <= v[15:0];
        else if (ch < 4) bus_s <= v[15:0];
        else half_s <= v[15:0] + 16'h0001;
        ticks(ch, n);
        if (n >= 6 && !mfw[bp[ch]] && (up ? v > thr[ch] : v < thr[ch])) mfw[bp[ch]] = 1'b1;
        else if (n >= 6 && mfw[bp[ch]] && (up ? v < thr[ch] - hys[ch] : v > thr[ch] + hys[ch]))
            mfw[bp[ch]] = 1'b0;
        repeat (8) @(posedge clk);
        #10;
        chk("fault word", mfw, fw);
        chk("duty zero", |mfw[5:1], duty);
        chk("run status", ~|mfw[5:1], runst);
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        do_reset();
        for (int k = 0; k < 8; k++) rreg(ra[k], {16'h0, rv[k]});
        for (int k = 0; k < 19; k++) wreg(cfg[k][23:16], {16'h0, cfg[k][15:0]});
        rreg(8'h20, 32'h3e8);
        wreg(8'h00, 32'h3);
        rreg(8'h00, 32'h3);
        pulse(16'h0100);
        rreg(8'h08, 32'h9);
        for (int ch = 0; ch < 6; ch++) begin
            r = seed % (ch > 3 ? 2 : 50);
            o = (ch % 2 == 0) ? thr[ch] + 1 + r : thr[ch] - 1 - r;
            b = (ch % 2 == 0) ? thr[ch] - hys[ch] / 2 : thr[ch] + hys[ch] / 2;
            phase(ch, o, 3);
            phase(ch, nom[ch], 3);
            phase(ch, o, 3);
            phase(ch, o, 9);
            rreg(8'h08, 32'ha);
            phase(ch, b, 9);
            phase(ch, nom[ch], 3);
            phase(ch, b, 3);
            phase(ch, nom[ch], 9);
            $display("channel %0d done", ch);
        end
        rreg(8'h10, 32'hd);
        rreg(8'h14, 32'h7d0);
        rreg(8'h0c, 32'h320);
        do_reset();
        wreg(8'h80, 32'h64);
        wreg(8'h84, 32'hc8);
        wreg(8'h00, 32'h1);
        pulse(16'h0032);
        chk("fault word", 32'h80, fw);
        chk("start block", 32'h1, blk);
        rreg(8'h08, 32'hc);
        wreg(8'h00, 32'h0);
        wreg(8'h00, 32'h1);
        pulse(16'h0096);
        rreg(8'h04, 32'h80);
        do_reset();
        rreg(8'h04, 32'h0);
        $display("offset test done");
        test_done();
    end
endmodule
`default_nettype wire
